/* design/lvd_defines.svh */
`ifndef LVD_DEFINES_SVH
`define LVD_DEFINES_SVH

// ****************************************************************
// register indices (byte address is four times the index)
// ****************************************************************
`define LVD_IDX_CTRL       8'h1F
`define LVD_IDX_VEN        8'h20
`define LVD_IDX_VSTAT      8'h21
`define LVD_IDX_WDC        8'h22

// ****************************************************************
// field positions
// ****************************************************************
`define LVD_CTRL_IRQ_EN    0
`define LVD_CTRL_WAKE_EN   1
`define LVD_CTRL_CROSS     2
`define LVD_CTRL_WDT       3
`define LVD_CTRL_DIV_LO    4
`define LVD_VEN_RST_EN     6
`define LVD_VEN_DET_EN     7
`define LVD_VSTAT_ABOVE    3
`define LVD_WDC_WARM       5

// ****************************************************************
// reset values
// ****************************************************************
`define LVD_CTRL_RESET     6'h00
`define LVD_VEN_RESET      2'h0

// ****************************************************************
// sampling divider masks (divide by 8, 16, 32, 64)
// ****************************************************************
`define LVD_MASK_DIV8      6'h07
`define LVD_MASK_DIV16     6'h0F
`define LVD_MASK_DIV32     6'h1F
`define LVD_MASK_DIV64     6'h3F

`endif

/* design/lvd_pkg.sv */
package lvd_pkg;

  // control register image, bits 5:0
  typedef struct packed {
    logic [1:0] div_sel;
    logic       wdt_flag;
    logic       cross_flag;
    logic       wake_en;
    logic       irq_en;
  } lvd_ctrl_s;

  // operating mode of the core
  typedef enum logic [1:0] {
    LVD_NORMAL = 2'b00,
    LVD_WAIT   = 2'b01,
    LVD_STOP   = 2'b10
  } lvd_mode_e;

endpackage : lvd_pkg

/* design/lvd_top.sv */
// What this block does
// - force chip reset while supply at or below reset threshold
// - reset-level path inactive during stop mode
// - status bit shows supply above mid threshold
// - 8-bit control register at index 1Fh, clears to 00h
// - interrupt enable only works while detector enable is 1
// - crossing flag set on every sampled mid-threshold crossing
// - request on crossing flag rising with both enables set, in normal or clocked wait mode
// - stop mode with wake enable: request and wake on supply above
// - sampling clock is cpu clock divided by 8, 16, 32 or 64
// - request comes within one sampling period of status change
// - wait mode: flag rise, or status rise if peripheral clock stopped
// - stop request while enabled and supply above: request at once
// - wait entry with clock stopped and supply above: request at once
// - request shares one vector with watchdog and oscillator events
// - watchdog overflow flag reads 1 once overflow detected
// - upper two register bits read 0
// - start-up flag 0 at power-on, set by watchdog control write
// - start-up flag survives every reset except power-on
`timescale 1ns/1ps
`default_nettype none
`include "lvd_defines.svh"

module lvd_top
  import lvd_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  // apb slave
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  // power-on reset, clears the start-up flag
  input  wire logic              por_n,
  // analogue comparators, asynchronous
  input  wire logic              cmp_at_reset_level,
  input  wire logic              cmp_above_mid,
  // cpu mode and events, same clock
  input  wire logic              stop_mode,
  input  wire logic              wait_mode,
  input  wire logic              periph_clock_stop_in_wait,
  input  wire logic              stop_request,
  input  wire logic              wait_exec,
  input  wire logic              watchdog_overflow,
  input  wire logic              watchdog_irq,
  input  wire logic              osc_detect_irq,
  // results
  output logic                   chip_reset_req,
  output logic                   lv_irq,
  output logic                   wake_req,
  output logic                   shared_vector_irq,
  output logic                   warm_start_flag
);

  // ****************************************************************
  // divider mask decode
  // ****************************************************************
  function automatic logic [5:0] lvd_div_mask(input logic [1:0] sel);
    unique case (sel)
      2'b00: lvd_div_mask = `LVD_MASK_DIV8;
      2'b01: lvd_div_mask = `LVD_MASK_DIV16;
      2'b10: lvd_div_mask = `LVD_MASK_DIV32;
      2'b11: lvd_div_mask = `LVD_MASK_DIV64;
    endcase
  endfunction : lvd_div_mask

  // byte addresses, four times the register index
  localparam logic [ADDR_W-1:0] ADDR_CTRL  = ADDR_W'({`LVD_IDX_CTRL, 2'b00});
  localparam logic [ADDR_W-1:0] ADDR_VEN   = ADDR_W'({`LVD_IDX_VEN, 2'b00});
  localparam logic [ADDR_W-1:0] ADDR_VSTAT = ADDR_W'({`LVD_IDX_VSTAT, 2'b00});
  localparam logic [ADDR_W-1:0] ADDR_WDC   = ADDR_W'({`LVD_IDX_WDC, 2'b00});

  lvd_ctrl_s  ctrl;
  logic       det_en;
  logic       rst_lvl_en;
  logic       wake_used;
  logic [5:0] div_cnt;
  logic       tick;
  logic [1:0] low_sync;
  logic [1:0] mid_sync;
  logic       samp_above;
  logic       access;
  logic       wr_done;
  logic       wr_ctrl;
  logic       wr_ven;
  logic       wr_wdc;
  logic       cross_set;
  logic       rise_tick;
  logic       wake_ok;
  logic       irq_gate;
  logic       fire_normal;
  logic       fire_wake;
  lvd_mode_e  mode;

  // ****************************************************************
  // comparator synchronisers
  // ****************************************************************
  // two flops before any use
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      low_sync <= 2'b00;
      mid_sync <= 2'b00;
    end
    else
    begin
      low_sync <= {low_sync[0], cmp_at_reset_level};
      mid_sync <= {mid_sync[0], cmp_above_mid};
    end
  end

  // ****************************************************************
  // reset-level detection
  // ****************************************************************
  // reset request, masked in stop
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      chip_reset_req <= 1'b0;
    else
      chip_reset_req <= rst_lvl_en & low_sync[1] & ~stop_mode;
  end

  // ****************************************************************
  // sampling divider
  // ****************************************************************
  // free-running count, tick when masked bits all ones
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      div_cnt <= 6'h00;
    else
      div_cnt <= div_cnt + 6'h01;
  end

  assign tick = ((div_cnt & lvd_div_mask(ctrl.div_sel))
                 == lvd_div_mask(ctrl.div_sel));

  // status is captured only on a sampling tick
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      samp_above <= 1'b0;
    else if (tick)
      samp_above <= mid_sync[1];
  end

  // ****************************************************************
  // mode and request conditions
  // ****************************************************************
  // stop takes precedence if both mode levels are seen
  always_comb
  begin
    if (stop_mode)
      mode = LVD_STOP;
    else if (wait_mode)
      mode = LVD_WAIT;
    else
      mode = LVD_NORMAL;
  end

  assign cross_set = tick & det_en & (mid_sync[1] != samp_above);
  assign rise_tick = tick & mid_sync[1] & ~samp_above;
  // wake is spent until the enable is written 0 again
  assign wake_ok   = ctrl.wake_en & ~wake_used;
  // interrupt enable gated by detector enable
  assign irq_gate  = det_en & ctrl.irq_en;

  // flag rise in normal or clocked wait
  assign fire_normal = irq_gate & cross_set & ~ctrl.cross_flag
                       & ((mode == LVD_NORMAL)
                          | ((mode == LVD_WAIT)
                             & ~periph_clock_stop_in_wait));

  assign fire_wake = irq_gate & wake_ok
                     & (((mode == LVD_STOP) & rise_tick)
                        | ((mode == LVD_WAIT) & periph_clock_stop_in_wait
                           & rise_tick)
                        | (stop_request & mid_sync[1])
                        | (wait_exec & periph_clock_stop_in_wait
                           & mid_sync[1]));

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lv_irq   <= 1'b0;
      wake_req <= 1'b0;
    end
    else
    begin
      lv_irq   <= fire_normal | fire_wake;
      wake_req <= fire_wake;
    end
  end

  // one shared vector for three sources
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      shared_vector_irq <= 1'b0;
    else
      shared_vector_irq <= fire_normal | fire_wake
                           | watchdog_irq | osc_detect_irq;
  end

  // ****************************************************************
  // apb decode
  // ****************************************************************
  // one wait state so every answer comes from a flop
  assign access  = psel & penable & ~pready;
  // writes land on the completion edge, when pready is seen high
  assign wr_done = psel & penable & pready & pwrite;
  assign wr_ctrl = wr_done & (paddr == ADDR_CTRL);
  assign wr_ven  = wr_done & (paddr == ADDR_VEN);
  assign wr_wdc  = wr_done & (paddr == ADDR_WDC);

  // ****************************************************************
  // control register
  // ****************************************************************
  // flags set beat a clearing write
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl <= `LVD_CTRL_RESET;
    else
    begin
      if (wr_ctrl)
      begin
        ctrl.irq_en  <= pwdata[`LVD_CTRL_IRQ_EN];
        ctrl.wake_en <= pwdata[`LVD_CTRL_WAKE_EN];
        ctrl.div_sel <= pwdata[`LVD_CTRL_DIV_LO +: 2];
      end
      if (cross_set)
        ctrl.cross_flag <= 1'b1;
      else if (wr_ctrl && !pwdata[`LVD_CTRL_CROSS])
        ctrl.cross_flag <= 1'b0;
      if (watchdog_overflow)
        ctrl.wdt_flag <= 1'b1;
      else if (wr_ctrl && !pwdata[`LVD_CTRL_WDT])
        ctrl.wdt_flag <= 1'b0;
    end
  end

  // wake spent after use, rearmed by writing enable 0
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      wake_used <= 1'b0;
    else if (fire_wake)
      wake_used <= 1'b1;
    else if (wr_ctrl && !pwdata[`LVD_CTRL_WAKE_EN])
      wake_used <= 1'b0;
  end

  // detector and reset-level enables
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      {det_en, rst_lvl_en} <= `LVD_VEN_RESET;
    else if (wr_ven)
    begin
      det_en     <= pwdata[`LVD_VEN_DET_EN];
      rst_lvl_en <= pwdata[`LVD_VEN_RST_EN];
    end
  end

  always_ff @(posedge pclk or negedge por_n)
  begin
    if (!por_n)
      warm_start_flag <= 1'b0;
    else if (wr_wdc)
      warm_start_flag <= 1'b1;
  end

  // ****************************************************************
  // apb answer
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= access;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      if (access)
      begin
        unique case (paddr)
          ADDR_CTRL:
            prdata[5:0] <= ctrl;
          ADDR_VEN:
          begin
            prdata[`LVD_VEN_DET_EN] <= det_en;
            prdata[`LVD_VEN_RST_EN] <= rst_lvl_en;
          end
          ADDR_VSTAT:
            prdata[`LVD_VSTAT_ABOVE] <= mid_sync[1];
          ADDR_WDC:
            prdata[`LVD_WDC_WARM] <= warm_start_flag;
          default:
            pslverr <= 1'b1;
        endcase
      end
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_stop_armed;
    stop_request && irq_gate && wake_ok && mid_sync[1];
  endsequence

  sequence s_wake_out;
    lv_irq && wake_req;
  endsequence

  a_reset_level: assert property (
    rst_lvl_en && low_sync[1] && !stop_mode |=> chip_reset_req)
    else $error("reset level not forcing reset");

  a_stop_no_reset: assert property (
    stop_mode |=> !chip_reset_req)
    else $error("reset request during stop");

  a_irq_gated: assert property (
    lv_irq |-> $past(irq_gate))
    else $error("request without both enables");

  a_flag_sticky: assert property (
    ctrl.cross_flag && !(wr_ctrl && !pwdata[`LVD_CTRL_CROSS])
    |=> ctrl.cross_flag)
    else $error("crossing flag dropped without write");

  a_flag_irq: assert property (
    $rose(ctrl.cross_flag) && $past(irq_gate && mode == LVD_NORMAL)
    |-> lv_irq)
    else $error("no request on flag rise");

  a_div_spacing: assert property (
    tick && ctrl.div_sel == 2'b00 && !wr_ctrl |=> !tick [*7])
    else $error("sampling tick too early");

  a_stop_wake: assert property (
    s_stop_armed |=> s_wake_out)
    else $error("stop request did not wake");

  a_warm_start: assert property (
    wr_wdc |=> warm_start_flag)
    else $error("warm start flag not set");

  a_apb_answer: assert property (
    access |=> pready ##1 !pready)
    else $error("apb answer not one cycle");

endmodule : lvd_top
`default_nettype wire

/* verif/lvd_supply_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// supply comparators facing the block
// ****************************************************************
module lvd_supply_model
(
  // supply level: 0 at/below reset, 1 between, 2 above mid
  input  wire logic [1:0] level,
  // comparator outputs, asynchronous to the block clock
  output logic            cmp_at_reset_level,
  output logic            cmp_above_mid
);
  // ideal comparators; no hysteresis, so the bench sets clean steps
  assign cmp_at_reset_level = (level == 2'h0);
  assign cmp_above_mid      = (level == 2'h2);
endmodule : lvd_supply_model

`default_nettype wire

/* verif/low_voltage_detect_irq_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "lvd_defines.svh"

module low_voltage_detect_irq_bench
  import lvd_pkg::*;
;
  logic        pclk, presetn, por_n, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, err, cmp_rst, cmp_mid;
  logic [1:0]  level;
  logic        stop_mode, wait_mode, clk_stop, stop_req, wait_exec;
  logic        wdt_ovf, wdt_irq, osc_irq, chip_rst, lv_irq, wake;
  logic        shared_irq, warm;
  int          fails = 0, checks = 0, cyc = 0;
  int          n_irq = 0, n_wake = 0, n_sh = 0, irq_at = 0, t0;

  lvd_top #(.ADDR_W(12)) uut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .por_n(por_n), .cmp_at_reset_level(cmp_rst),
    .cmp_above_mid(cmp_mid), .stop_mode(stop_mode),
    .wait_mode(wait_mode), .periph_clock_stop_in_wait(clk_stop),
    .stop_request(stop_req), .wait_exec(wait_exec),
    .watchdog_overflow(wdt_ovf), .watchdog_irq(wdt_irq),
    .osc_detect_irq(osc_irq), .chip_reset_req(chip_rst),
    .lv_irq(lv_irq), .wake_req(wake), .shared_vector_irq(shared_irq),
    .warm_start_flag(warm));

  lvd_supply_model sup (.level(level), .cmp_at_reset_level(cmp_rst),
    .cmp_above_mid(cmp_mid));

  // 20 MHz clock
  initial
  begin
    pclk = 1'h0;
    forever #25 pclk = ~pclk;
  end

  // pulse counters, sampled mid-cycle where outputs are settled
  always @(negedge pclk)
  begin
    cyc = cyc + 1;
    n_wake = n_wake + int'(wake === 1'h1);
    n_sh = n_sh + int'(shared_irq === 1'h1);
    if (lv_irq === 1'h1)
    begin
      n_irq = n_irq + 1;
      irq_at = cyc;
    end
  end

  // hang guard, well above the several hundred cycles the run needs
  always @(posedge pclk)
    if (cyc > 20000)
    begin
      fails = fails + 1;
      end_of_test();
    end

  task automatic chk(input string what, input logic [31:0] got,
                     input logic [31:0] exp);
    checks = checks + 1;
    if (got !== exp)
    begin
      fails = fails + 1;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] idx,
                     input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp,
                       input string what);
    apb(1'h0, idx, 32'h0);
    chk(what, rd, exp);
  endtask : rdchk

  task automatic t_regs();
    rdchk(`LVD_IDX_CTRL, 32'h00, "ctrl reset");
    apb(1'h1, `LVD_IDX_CTRL, 32'hFF);
    rdchk(`LVD_IDX_CTRL, 32'h33, "ctrl upper bits");
    @(posedge pclk) wdt_ovf <= 1'h1;
    @(posedge pclk) wdt_ovf <= 1'h0;
    rdchk(`LVD_IDX_CTRL, 32'h3B, "wdt flag");
    apb(1'h0, 8'h3F, 32'h0);
    chk("unmapped err", 32'(err), 32'h1);
    apb(1'h1, `LVD_IDX_CTRL, 32'h00);
    $display("test regs done");
  endtask : t_regs

  task automatic t_rst();
    apb(1'h1, `LVD_IDX_VEN, 32'h40);
    level <= 2'h0;
    repeat (8) @(posedge pclk);
    chk("reset req low", 32'(chip_rst), 32'h1);
    stop_mode <= 1'h1;
    repeat (8) @(posedge pclk);
    chk("reset req stop", 32'(chip_rst), 32'h0);
    stop_mode <= 1'h0;
    level <= 2'h1;
    repeat (8) @(posedge pclk);
    chk("reset req off", 32'(chip_rst), 32'h0);
    $display("test reset level done");
  endtask : t_rst

  task automatic t_cross();
    int n, m;
    m = n_sh;
    // enable detector, wait activation and one period
    apb(1'h1, `LVD_IDX_VEN, 32'h80);
    repeat (70) @(posedge pclk);
    apb(1'h1, `LVD_IDX_CTRL, 32'h01);
    n = n_irq;
    t0 = cyc;
    level <= 2'h2;
    repeat (30) @(posedge pclk);
    chk("irq on rise", n_irq - n, 32'h1);
    chk("irq delay", irq_at - t0 inside {[3:13]}, 32'h1);
    chk("shared vector", n_sh - m, 32'h1);
    // the other two sources reach the shared vector only
    m = n_sh;
    @(posedge pclk) wdt_irq <= 1'h1;
    @(posedge pclk) wdt_irq <= 1'h0;
    @(posedge pclk) osc_irq <= 1'h1;
    @(posedge pclk) osc_irq <= 1'h0;
    repeat (2) @(posedge pclk);
    chk("shared sources", n_sh - m, 32'h2);
    chk("no lv from others", n_irq - n, 32'h1);
    rdchk(`LVD_IDX_VSTAT, 32'h08, "status above");
    rdchk(`LVD_IDX_CTRL, 32'h05, "flag on rise");
    level <= 2'h1;
    repeat (30) @(posedge pclk);
    chk("flag held no irq", n_irq - n, 32'h1);
    rdchk(`LVD_IDX_VSTAT, 32'h00, "status below");
    apb(1'h1, `LVD_IDX_CTRL, 32'h01);
    rdchk(`LVD_IDX_CTRL, 32'h01, "flag cleared");
    $display("test crossing done");
  endtask : t_cross

  // rising and falling crossings alternate with each divider code
  task automatic t_div();
    int d, n;
    for (d = 0; d < 4; d++)
    begin
      apb(1'h1, `LVD_IDX_CTRL, 32'(d << 4) | 32'h01);
      n = n_irq;
      t0 = cyc;
      level <= (d % 2 == 0) ? 2'h2 : 2'h1;
      repeat ((8 << d) + 12) @(posedge pclk);
      chk("irq per code", n_irq - n, 32'h1);
      chk("code delay", irq_at - t0 <= (8 << d) + 5, 32'h1);
      rdchk(`LVD_IDX_CTRL, 32'(d << 4) | 32'h05, "flag");
    end
    $display("test divider done");
  endtask : t_div

  task automatic t_off();
    int n;
    apb(1'h1, `LVD_IDX_CTRL, 32'h01);
    apb(1'h1, `LVD_IDX_VEN, 32'h00);
    n = n_irq;
    level <= 2'h2;
    repeat (40) @(posedge pclk);
    chk("no irq detector off", n_irq - n, 32'h0);
    rdchk(`LVD_IDX_CTRL, 32'h01, "no flag off");
    level <= 2'h1;
    apb(1'h1, `LVD_IDX_VEN, 32'h80);
    repeat (70) @(posedge pclk);
    $display("test disabled done");
  endtask : t_off

  task automatic t_stop();
    int n, m;
    apb(1'h1, `LVD_IDX_CTRL, 32'h03);
    // sleep is entered only while the status reads 0
    rdchk(`LVD_IDX_VSTAT, 32'h00, "status before stop");
    stop_mode <= 1'h1;
    n = n_wake;
    m = n_irq;
    level <= 2'h2;
    repeat (20) @(posedge pclk);
    chk("stop wake", n_wake - n, 32'h1);
    chk("stop irq", n_irq - m, 32'h1);
    level <= 2'h1;
    repeat (20) @(posedge pclk);
    level <= 2'h2;
    repeat (20) @(posedge pclk);
    chk("wake blocked", n_wake - n, 32'h1);
    stop_mode <= 1'h0;
    // rearm by writing 0 then 1
    apb(1'h1, `LVD_IDX_CTRL, 32'h01);
    apb(1'h1, `LVD_IDX_CTRL, 32'h03);
    stop_req <= 1'h1;
    @(posedge pclk) stop_req <= 1'h0;
    repeat (4) @(posedge pclk);
    chk("stop entry wake", n_wake - n, 32'h2);
    $display("test stop done");
  endtask : t_stop

  task automatic t_wait();
    int n, m;
    apb(1'h1, `LVD_IDX_CTRL, 32'h01);
    apb(1'h1, `LVD_IDX_CTRL, 32'h03);
    n = n_wake;
    wait_mode <= 1'h1;
    clk_stop <= 1'h1;
    wait_exec <= 1'h1;
    @(posedge pclk) wait_exec <= 1'h0;
    repeat (4) @(posedge pclk);
    chk("wait entry wake", n_wake - n, 32'h1);
    // clocked wait: the flag rise requests, no wake
    clk_stop <= 1'h0;
    level <= 2'h1;
    repeat (20) @(posedge pclk);
    apb(1'h1, `LVD_IDX_CTRL, 32'h01);
    n = n_wake;
    m = n_irq;
    level <= 2'h2;
    repeat (20) @(posedge pclk);
    chk("wait clocked irq", n_irq - m, 32'h1);
    chk("wait clocked no wake", n_wake - n, 32'h0);
    // stopped clock: the status rise wakes
    apb(1'h1, `LVD_IDX_CTRL, 32'h03);
    clk_stop <= 1'h1;
    level <= 2'h1;
    repeat (20) @(posedge pclk);
    n = n_wake;
    level <= 2'h2;
    repeat (20) @(posedge pclk);
    chk("wait stopped wake", n_wake - n, 32'h1);
    wait_mode <= 1'h0;
    clk_stop <= 1'h0;
    $display("test wait done");
  endtask : t_wait

  task automatic t_warm();
    apb(1'h1, `LVD_IDX_WDC, 32'h00);
    @(posedge pclk);
    chk("warm after write", 32'(warm), 32'h1);
    rdchk(`LVD_IDX_WDC, 32'h20, "warm read");
    presetn <= 1'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    chk("warm kept", 32'(warm), 32'h1);
    rdchk(`LVD_IDX_CTRL, 32'h00, "ctrl after reset");
    $display("test warm start done");
  endtask : t_warm

  task automatic end_of_test();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_of_test

  // main sequence
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {stop_mode, wait_mode, clk_stop, stop_req, wait_exec} = '0;
    {wdt_ovf, wdt_irq, osc_irq, presetn, por_n} = '0;
    level = 2'h1;
    repeat (20) @(posedge pclk);
    presetn <= 1'h1;
    por_n <= 1'h1;
    chk("cold start", 32'(warm), 32'h0);
    t_regs();
    t_rst();
    t_cross();
    t_div();
    t_off();
    t_stop();
    t_wait();
    t_warm();
    end_of_test();
  end
endmodule : low_voltage_detect_irq_bench

`default_nettype wire
